/* File: include/fsbb_consts.svh */
// Constants for the four-switch buck-boost gate sequencer
`ifndef FSBB_CONSTS_SVH
`define FSBB_CONSTS_SVH

`define CLK_NS           25
`define T_MIN_ON_NS      200
`define T_MIN_OFF_NS     230
`define PERIOD_CYC_DEF   100
`define DEAD_CYC_DEF     2
`define OVL_STEP_DEF     4
`define SYNC_W           13

`define ADDR_CTRL        8'h00
`define ADDR_STATUS      8'h04
`define CTRL_RESET       1'b0
`define CTRL_EN_BIT      0
`define ST_REGION_LSB    0
`define ST_COND_LSB      2
`define ST_REFRESH_BIT   5
`define ST_RVS_BIT       6
`define ST_RUN_BIT       7
`define ST_OVL_LSB       8
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

/* File: include/fsbb_pkg.sv */
// Types shared by the gate sequencer
package fsbb_pkg;

    typedef enum logic [1:0] {REG_BUCK, REG_BB, REG_BOOST} region_t;

    typedef enum logic [1:0] {PH_FIRST, PH_MID, PH_SECOND, PH_LAST} phase_t;

    typedef enum logic [2:0] {
        CM_CONT, CM_DISC_FWD, CM_DISC_REV, CM_HYB_FWD, CM_HYB_REV,
        CM_SKIP, CM_NONE
    } cond_t;

    typedef enum logic [1:0] {LEG_OFF, LEG_LOW, LEG_HIGH} leg_t;

endpackage : fsbb_pkg

/* File: verilog/input_sync.sv */
// Two-flop synchroniser for a bundle of independent pin levels
`timescale 1ns/1ps
module input_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    // The first stage feeds only the second stage
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.meta = d;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.sync;

endmodule : input_sync

/* File: verilog/four_switch_buck_boost_sequencer.sv */
// Gate sequencer for a four-switch buck-boost stage with AXI4-Lite regs
//
// Operation
// - Buck: output leg high, input low then high
// - Too-short buck bottom on-time enters buck-boost
// - Buck input bottom off-time kept above minimum
// - Buck-first buck-boost cycle: buck, mid, boost, end
// - Boost-first buck-boost cycle: boost, mid, buck, end
// - Boost: input leg high, output low then high
// - Boost bottom minimum on and off time, exit
// - Early soft-start: both tops never on together
// - Later soft-start: top overlap grows with ramp
// - Low bootstrap during soft-start: both bottoms refresh
// - Decode conduction mode from mode band, direction
// - Top mode band: forward pulse skipping only; code stops all switching in this band when reverse inhibit is low
// - Direction selects forward or reverse flow
// - Reverse inhibit low blocks all reverse flow
// - Reverse inhibit open drain, pulled on faults
// - Continuous mode: switches run at any control level
// - Unidirectional modes override opposite control demand
// - Forward discontinuous: low control stops flow
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "fsbb_consts.svh"
module four_switch_buck_boost_sequencer import fsbb_pkg::*; #(
    parameter int PERIOD_CYC = `PERIOD_CYC_DEF,
    parameter int DEAD_CYC   = `DEAD_CYC_DEF,
    parameter int OVL_STEP   = `OVL_STEP_DEF
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        buck_current_comparator,
    input  wire logic        boost_current_comparator,
    input  wire logic        softstart_active,
    input  wire logic        softstart_above_first,
    input  wire logic [1:0]  bootstrap_low,
    input  wire logic [1:0]  mode_band,
    input  wire logic        direction_select,
    input  wire logic        control_high,
    input  wire logic        output_undervoltage_monitor,
    input  wire logic        input_overvoltage_monitor,
    input  wire logic        reverse_inhibit_n_i,
    output logic             reverse_inhibit_n_o,
    output logic             reverse_inhibit_n_oe,
    output logic             input_top_switch,
    output logic             input_bottom_switch,
    output logic             output_top_switch,
    output logic             output_bottom_switch,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam int MIN_ON_CYC  = (`T_MIN_ON_NS + `CLK_NS - 1) / `CLK_NS;
    localparam int MIN_OFF_CYC = (`T_MIN_OFF_NS + `CLK_NS - 1) / `CLK_NS;
    typedef logic [7:0] cnt_t;
    localparam cnt_t PER_C    = cnt_t'(PERIOD_CYC);
    localparam cnt_t LAST_C   = cnt_t'(PERIOD_CYC - 1);
    localparam cnt_t HALF_C   = cnt_t'(PERIOD_CYC / 2);
    localparam cnt_t OFF_AT_C = cnt_t'(PERIOD_CYC - MIN_OFF_CYC);
    localparam cnt_t MIN_ON_C = cnt_t'(MIN_ON_CYC);
    localparam cnt_t STEP_C   = cnt_t'(OVL_STEP);
    localparam cnt_t DEAD_C   = cnt_t'(DEAD_CYC);

    typedef struct packed {
        region_t          region;
        phase_t           phase;
        cond_t            cond;
        logic             boost_first;
        logic             short_first;
        logic             short_second;
        logic             refresh;
        logic             rvs_drive;
        logic             sw_enable;
        cnt_t             cyc;
        cnt_t             ovl_allow;
        cnt_t             ovl_cnt;
        logic [1:0]       top;
        logic [1:0]       bot;
        logic [1:0][7:0]  dead;
        logic [1:0][7:0]  bot_len;
        logic             aw_got;
        logic             w_got;
        logic [7:0]       awaddr;
        logic [31:0]      wdata;
        logic             wstrb0;
        logic             awready;
        logic             wready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    logic [`SYNC_W-1:0] raw_pins;
    logic [`SYNC_W-1:0] syn;
    logic               buck_trip;
    logic               boost_trip;
    logic               ss_act;
    logic               ss_above;
    logic [1:0]         boot_low;
    logic [1:0]         band;
    logic               dir_fwd;
    logic               ctl_high;
    logic               uv_s;
    logic               ov_s;
    logic               rvs_ok;
    logic               run;

    assign raw_pins = {buck_current_comparator, boost_current_comparator,
                       softstart_active, softstart_above_first,
                       bootstrap_low, mode_band, direction_select,
                       control_high, output_undervoltage_monitor,
                       input_overvoltage_monitor, reverse_inhibit_n_i};

    input_sync #(.WIDTH(`SYNC_W)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (raw_pins),
        .q       (syn)
    );

    assign {buck_trip, boost_trip, ss_act, ss_above, boot_low, band,
            dir_fwd, ctl_high, uv_s, ov_s, rvs_ok} = syn;

    // Direction permission comes from the registered mode decode
    always_comb begin
        unique case (st_ff.cond)
            CM_CONT:                         run = 1'b1;
            CM_DISC_FWD, CM_HYB_FWD, CM_SKIP: run = ctl_high;
            CM_DISC_REV, CM_HYB_REV:         run = !ctl_high;
            default:                         run = 1'b0;
        endcase
        run = run & st_ff.sw_enable;
    end

    always_comb begin
        leg_t   in_d;
        leg_t   out_d;
        leg_t   want;
        logic   in_ok;
        logic   out_ok;
        logic   force_off;
        nxt_st    = st_ff;
        in_d      = LEG_OFF;
        out_d     = LEG_OFF;
        want      = LEG_OFF;
        in_ok     = st_ff.bot_len[0] >= MIN_ON_C;
        out_ok    = st_ff.bot_len[1] >= MIN_ON_C;
        force_off = st_ff.cyc >= OFF_AT_C;
        nxt_st.cyc = (st_ff.cyc == LAST_C) ? '0 : st_ff.cyc + 8'h01;

        // Conduction mode decode
        unique case (band)
            2'h0: nxt_st.cond = rvs_ok ? CM_CONT : CM_DISC_FWD;
            2'h1: nxt_st.cond = dir_fwd ? CM_HYB_FWD :
                                (rvs_ok ? CM_HYB_REV : CM_NONE);
            2'h2: nxt_st.cond = dir_fwd ? CM_DISC_FWD :
                                (rvs_ok ? CM_DISC_REV : CM_NONE);
            2'h3: nxt_st.cond = rvs_ok ? CM_SKIP : CM_NONE;
        endcase
        nxt_st.rvs_drive = uv_s | ov_s;

        // Per-cycle switch sequence by region and phase
        unique case (st_ff.region)
            REG_BUCK: begin
                out_d = LEG_HIGH;
                if (st_ff.phase == PH_FIRST) begin
                    in_d = LEG_LOW;
                    if (buck_trip && !in_ok) nxt_st.short_first = 1'b1;
                    if ((buck_trip || force_off) && in_ok)
                        nxt_st.phase = PH_LAST;
                end else begin
                    in_d = LEG_HIGH;
                end
            end
            REG_BOOST: begin
                in_d = LEG_HIGH;
                if (st_ff.phase == PH_FIRST) begin
                    out_d = LEG_LOW;
                    if (boost_trip && !out_ok) nxt_st.short_first = 1'b1;
                    if ((boost_trip || force_off) && out_ok)
                        nxt_st.phase = PH_LAST;
                end else begin
                    out_d = LEG_HIGH;
                end
            end
            default: begin
                in_d  = LEG_HIGH;
                out_d = LEG_HIGH;
                unique case (st_ff.phase)
                    PH_FIRST: begin
                        if (!st_ff.boost_first) begin
                            in_d = LEG_LOW;
                            if (buck_trip) begin
                                nxt_st.phase = PH_MID;
                                if (!in_ok) nxt_st.short_first = 1'b1;
                            end
                        end else begin
                            out_d = LEG_LOW;
                            if (boost_trip) begin
                                nxt_st.phase = PH_MID;
                                if (!out_ok) nxt_st.short_first = 1'b1;
                            end
                        end
                    end
                    PH_MID: begin
                        if (st_ff.cyc >= HALF_C) nxt_st.phase = PH_SECOND;
                    end
                    PH_SECOND: begin
                        if (!st_ff.boost_first) begin
                            out_d = LEG_LOW;
                            if (boost_trip && !out_ok)
                                nxt_st.short_second = 1'b1;
                            if ((boost_trip && out_ok) || force_off)
                                nxt_st.phase = PH_LAST;
                        end else begin
                            in_d = LEG_LOW;
                            if (buck_trip && !in_ok)
                                nxt_st.short_second = 1'b1;
                            if ((buck_trip && in_ok) || force_off)
                                nxt_st.phase = PH_LAST;
                        end
                    end
                    PH_LAST: ;
                endcase
            end
        endcase

        // Region moves and soft-start bookkeeping at the cycle boundary
        if (st_ff.cyc == LAST_C) begin
            nxt_st.phase        = PH_FIRST;
            nxt_st.short_first  = 1'b0;
            nxt_st.short_second = 1'b0;
            nxt_st.refresh      = ss_act && (|boot_low);
            unique case (st_ff.region)
                REG_BUCK: if (st_ff.short_first) begin
                    nxt_st.region      = REG_BB;
                    nxt_st.boost_first = 1'b0;
                end
                REG_BOOST: if (st_ff.short_first) begin
                    nxt_st.region      = REG_BB;
                    nxt_st.boost_first = 1'b1;
                end
                default: begin
                    // A vanishing second half hands over to the pure region
                    if (st_ff.short_second)
                        nxt_st.region = st_ff.boost_first ? REG_BOOST
                                                          : REG_BUCK;
                    else if (st_ff.short_first)
                        nxt_st.boost_first = !st_ff.boost_first;
                end
            endcase
            if (!ss_act || !ss_above)
                nxt_st.ovl_allow = ss_act ? '0 : PER_C;
            else if (st_ff.ovl_allow >= PER_C - STEP_C)
                nxt_st.ovl_allow = PER_C;
            else
                nxt_st.ovl_allow = st_ff.ovl_allow + STEP_C;
        end

        // Soft-start limits on the both-tops interval
        if (in_d == LEG_HIGH && out_d == LEG_HIGH) begin
            nxt_st.ovl_cnt = (st_ff.ovl_cnt == PER_C) ? PER_C
                                                      : st_ff.ovl_cnt + 8'h01;
            if (ss_act && (!ss_above || st_ff.ovl_cnt >= st_ff.ovl_allow)) begin
                in_d  = LEG_OFF;
                out_d = LEG_OFF;
            end
        end else begin
            nxt_st.ovl_cnt = '0;
        end
        if (st_ff.refresh) begin
            in_d  = LEG_LOW;
            out_d = LEG_LOW;
        end
        if (!run) begin
            in_d  = LEG_OFF;
            out_d = LEG_OFF;
        end

        // Break-before-make per leg: index 0 input, 1 output
        for (int i = 0; i < 2; i++) begin
            want = (i == 0) ? in_d : out_d;
            if (want == LEG_OFF || (want == LEG_HIGH && st_ff.bot[i]) ||
                (want == LEG_LOW && st_ff.top[i])) begin
                nxt_st.top[i]  = 1'b0;
                nxt_st.bot[i]  = 1'b0;
                nxt_st.dead[i] = DEAD_C;
            end else if (!st_ff.top[i] && !st_ff.bot[i]) begin
                if (st_ff.dead[i] != '0) begin
                    nxt_st.dead[i] = st_ff.dead[i] - 8'h01;
                end else begin
                    nxt_st.top[i] = (want == LEG_HIGH);
                    nxt_st.bot[i] = (want == LEG_LOW);
                end
            end
            nxt_st.bot_len[i] = !nxt_st.bot[i] ? '0 :
                (st_ff.bot_len[i] == 8'hFF) ? 8'hFF : st_ff.bot_len[i] + 8'h01;
        end

        // AXI4-Lite write path
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_got  = 1'b1;
            nxt_st.wdata  = s_axi_wdata;
            nxt_st.wstrb0 = s_axi_wstrb[0];
        end
        if (st_ff.bvalid && s_axi_bready) nxt_st.bvalid = 1'b0;
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = `RESP_OKAY;
            if (st_ff.awaddr == `ADDR_CTRL) begin
                if (st_ff.wstrb0)
                    nxt_st.sw_enable = st_ff.wdata[`CTRL_EN_BIT];
            end else if (st_ff.awaddr != `ADDR_STATUS) begin
                nxt_st.bresp = `RESP_SLVERR;
            end
        end
        nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
        nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;

        // AXI4-Lite read path
        if (st_ff.rvalid && s_axi_rready) nxt_st.rvalid = 1'b0;
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = `RESP_OKAY;
            nxt_st.rdata  = '0;
            if (s_axi_araddr == `ADDR_CTRL) begin
                nxt_st.rdata[`CTRL_EN_BIT] = st_ff.sw_enable;
            end else if (s_axi_araddr == `ADDR_STATUS) begin
                nxt_st.rdata[`ST_REGION_LSB +: 2] = st_ff.region;
                nxt_st.rdata[`ST_COND_LSB +: 3]   = st_ff.cond;
                nxt_st.rdata[`ST_REFRESH_BIT]     = st_ff.refresh;
                nxt_st.rdata[`ST_RVS_BIT]         = st_ff.rvs_drive;
                nxt_st.rdata[`ST_RUN_BIT]         = run;
                nxt_st.rdata[`ST_OVL_LSB +: 8]    = st_ff.ovl_allow;
            end else begin
                nxt_st.rresp = `RESP_SLVERR;
            end
        end
        nxt_st.arready = !nxt_st.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign input_top_switch     = st_ff.top[0];
    assign input_bottom_switch  = st_ff.bot[0];
    assign output_top_switch    = st_ff.top[1];
    assign output_bottom_switch = st_ff.bot[1];
    assign reverse_inhibit_n_oe = st_ff.rvs_drive;
    assign reverse_inhibit_n_o  = !st_ff.rvs_drive;
    assign s_axi_awready        = st_ff.awready;
    assign s_axi_wready         = st_ff.wready;
    assign s_axi_bvalid         = st_ff.bvalid;
    assign s_axi_bresp          = st_ff.bresp;
    assign s_axi_arready        = st_ff.arready;
    assign s_axi_rvalid         = st_ff.rvalid;
    assign s_axi_rdata          = st_ff.rdata;
    assign s_axi_rresp          = st_ff.rresp;

    a_input_leg_bbm: assert property (@(posedge aclk) disable iff (!aresetn)
        !(input_top_switch && input_bottom_switch) &&
        !($fell(input_bottom_switch) && $rose(input_top_switch)))
        else $error("input leg overlap or no dead time");
    a_output_leg_bbm: assert property (@(posedge aclk) disable iff (!aresetn)
        !(output_top_switch && output_bottom_switch) &&
        !($fell(output_top_switch) && $rose(output_bottom_switch)))
        else $error("output leg overlap or no dead time");
    a_buck_out_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_ff.region == REG_BUCK && !st_ff.refresh) |=> !output_bottom_switch)
        else $error("output bottom on in buck region");
    a_boost_in_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_ff.region == REG_BOOST && !st_ff.refresh) |=> !input_bottom_switch)
        else $error("input bottom on in boost region");
    a_ss_no_tops: assert property (@(posedge aclk) disable iff (!aresetn)
        (ss_act && !ss_above) |=> !(input_top_switch && output_top_switch))
        else $error("both tops on in early soft-start");
    a_refresh_bots: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_ff.refresh && run) |=> !input_top_switch && !output_top_switch)
        else $error("top switch on during refresh");
    a_none_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_ff.cond == CM_NONE) |=> !input_top_switch && !input_bottom_switch
            && !output_top_switch && !output_bottom_switch)
        else $error("switching with no conduction allowed");
    a_rvs_pull: assert property (@(posedge aclk) disable iff (!aresetn)
        (uv_s || ov_s) |=> reverse_inhibit_n_oe && !reverse_inhibit_n_o)
        else $error("reverse inhibit not pulled on fault");
    a_buck_min_on: assert property (@(posedge aclk) disable iff (!aresetn)
        ($fell(input_bottom_switch) && $past(st_ff.region) == REG_BUCK &&
         $past(run) && !$past(ss_act)) |-> $past(st_ff.bot_len[0]) >= MIN_ON_C)
        else $error("buck bottom on-time below minimum");

endmodule : four_switch_buck_boost_sequencer

/* File: dv/stage_model.sv */
// Behavioural power stage: current comparators and pulled-up pin
`timescale 1ns/1ps
module stage_model (
    input  wire logic       aclk,
    input  wire logic       in_bot,
    input  wire logic       out_bot,
    input  wire logic [7:0] trip_clks,
    input  wire logic       ext_pull,
    input  wire logic       drv_oe,
    output logic            buck_trip,
    output logic            boost_trip,
    output logic            pin_level
);
    int in_cnt = 0, out_cnt = 0;
    always @(posedge aclk) begin
        in_cnt  <= in_bot ? in_cnt + 1 : 0;
        out_cnt <= out_bot ? out_cnt + 1 : 0;
    end
    // Sensed current crosses its reference trip_clks into each on-phase
    assign buck_trip  = in_bot && in_cnt >= trip_clks;
    assign boost_trip = out_bot && out_cnt >= trip_clks;
    // Pull-up wins unless someone sinks the line
    assign pin_level  = !(ext_pull || drv_oe);
endmodule : stage_model

/* File: dv/testbench.sv */
// Self-checking bench for the buck-boost gate sequencer
`timescale 1ns/1ps
`include "fsbb_consts.svh"
module testbench;
    logic        aclk = 1'h0, aresetn = 1'h0, mon_ss = 1'h0, ext_pull = 1'h0;
    logic        buck_current_comparator, boost_current_comparator;
    logic        softstart_active = 1'h0, softstart_above_first = 1'h0;
    logic [1:0]  bootstrap_low = 2'h0, mode_band = 2'h0, rsp;
    logic        direction_select = 1'h1, control_high = 1'h1;
    logic        output_undervoltage_monitor = 1'h0;
    logic        input_overvoltage_monitor = 1'h0;
    logic        reverse_inhibit_n_i, reverse_inhibit_n_o, reverse_inhibit_n_oe;
    logic        input_top_switch, input_bottom_switch;
    logic        output_top_switch, output_bottom_switch;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, trip_clks = 8'h14;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, st;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h1, s_axi_rvalid;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          fail_count = 0, num_checks = 0, e, n, mx, h;

    four_switch_buck_boost_sequencer u_dut (
        .aclk, .aresetn, .buck_current_comparator, .boost_current_comparator,
        .softstart_active, .softstart_above_first, .bootstrap_low, .mode_band,
        .direction_select, .control_high, .output_undervoltage_monitor,
        .input_overvoltage_monitor, .reverse_inhibit_n_i, .reverse_inhibit_n_o,
        .reverse_inhibit_n_oe, .input_top_switch, .input_bottom_switch,
        .output_top_switch, .output_bottom_switch, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    stage_model u_stage (.aclk(aclk), .in_bot(input_bottom_switch),
        .out_bot(output_bottom_switch), .trip_clks(trip_clks),
        .ext_pull(ext_pull), .drv_oe(reverse_inhibit_n_oe),
        .buck_trip(buck_current_comparator),
        .boost_trip(boost_current_comparator), .pin_level(reverse_inhibit_n_i));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic guard;
        if (n < 50) return;
        fail_count++;
        end_sim();
    endtask : guard
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && n < 50);
        rsp = s_axi_bresp;
        guard();
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && n < 50);
        st  = s_axi_rdata;
        rsp = s_axi_rresp;
        guard();
    endtask : rd
    function automatic int cond_of(int m, int d, int v);
        case (m)
            0: return v ? 0 : 1;
            1: return d ? 3 : (v ? 4 : 6);
            2: return d ? 1 : (v ? 2 : 6);
            default: return v ? 5 : 6;
        endcase
    endfunction : cond_of
    function automatic int run_of(int c, int hi);
        if (c == 6) return 0;
        if (c == 0) return 1;
        return (c == 2 || c == 4) ? 1 - hi : hi;
    endfunction : run_of

    always #12.5 aclk = ~aclk;
    always @(posedge aclk) begin
        if (aresetn) begin
            chk(32'(input_top_switch & input_bottom_switch), 32'h0);
            chk(32'(output_top_switch & output_bottom_switch), 32'h0);
            if (mon_ss) chk(32'(input_top_switch & output_top_switch), 32'h0);
        end
    end
    initial begin
        repeat (100000) @(posedge aclk);
        fail_count++;
        end_sim();
    end
    initial begin
        void'($urandom(32'hE3CE));
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`ADDR_CTRL);
        chk({st[30:0], input_top_switch}, 32'h0);
        rd(8'h10);
        chk({st[29:0], rsp}, 32'h2);
        wr(8'h10, 32'h1);
        chk(32'(rsp), 32'h2);
        wr(`ADDR_CTRL, 32'h1);
        for (int m = 0; m < 4; m++) for (int d = 0; d < 2; d++)
            for (int v = 0; v < 2; v++) begin
                h = $urandom % 2;
                @(posedge aclk);
                mode_band <= 2'(m);
                direction_select <= 1'(d);
                ext_pull <= 1'(1 - v);
                control_high <= 1'(h);
                // Hold each setting well past the shortest allowed pulse
                repeat (20) @(posedge aclk);
                rd(`ADDR_STATUS);
                e = cond_of(m, d, v);
                chk(32'(st[4:2]), 32'(e));
                chk(32'(st[7]), 32'(run_of(e, h)));
            end
        @(posedge aclk);
        direction_select <= 1'h1;
        ext_pull <= 1'h0;
        control_high <= 1'h1;
        repeat (20) @(posedge aclk);
        mode_band <= 2'h0;
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        wr(`ADDR_CTRL, 32'h1);
        for (int k = 0; k < 3; k++) begin
            @(posedge aclk);
            output_undervoltage_monitor <= 1'(k == 0);
            input_overvoltage_monitor <= 1'(k == 1);
            repeat (20) @(posedge aclk);
            rd(`ADDR_STATUS);
            e = {reverse_inhibit_n_oe, reverse_inhibit_n_o, st[6], st[4:2]};
            chk(32'(e), (k < 2) ? 32'h29 : 32'h10);
        end
        trip_clks <= 8'(20 + $urandom % 20);
        repeat (300) @(posedge aclk);
        rd(`ADDR_STATUS);
        chk(32'(st[1:0]), 32'h0);
        mx = 0;
        for (int i = 0; i < 100; i++) begin
            @(posedge aclk);
            chk(32'({output_top_switch, output_bottom_switch}), 32'h2);
            mx = mx | {input_top_switch, input_bottom_switch};
        end
        chk(32'(mx), 32'h3);
        trip_clks <= 8'hFF;
        e = 0;
        mx = 0;
        for (int i = 0; i < 400; i++) begin
            @(posedge aclk);
            e = input_bottom_switch ? e + 1 : 0;
            mx = (e > mx) ? e : mx;
        end
        chk(32'(mx >= 8 && mx <= `PERIOD_CYC_DEF - 10), 32'h1);
        trip_clks <= 8'h2;
        repeat (400) @(posedge aclk);
        mx = 0;
        for (int i = 0; i < 200; i++) begin
            @(posedge aclk);
            mx = mx | {st[1:0] != 2'h0, output_bottom_switch};
            if (i % 50 == 0) rd(`ADDR_STATUS);
        end
        chk(32'(mx[1]), 32'h1);
        chk(32'(mx[0]), 32'h1);
        trip_clks <= 8'h14;
        softstart_active <= 1'h1;
        bootstrap_low <= 2'h1;
        repeat (8) @(posedge aclk);
        mon_ss <= 1'h1;
        mx = 0;
        for (int i = 0; i < 300; i++) begin
            @(posedge aclk);
            mx = mx | (input_bottom_switch & output_bottom_switch);
        end
        chk(32'(mx), 32'h1);
        mon_ss <= 1'h0;
        softstart_above_first <= 1'h1;
        repeat (300) @(posedge aclk);
        rd(`ADDR_STATUS);
        chk(32'(st[15:8] != 8'h0), 32'h1);
        end_sim();
    end
endmodule : testbench
